/* rtl/cmd_interp_pkg.sv */
package cmd_interp_pkg;

  localparam logic [7:0] FRAME_START      = 8'h02;
  localparam logic [7:0] REPLY_BIT        = 8'h40;

  localparam logic [7:0] CODE_MODE_CHANGE = 8'h04;
  localparam logic [7:0] CODE_SOFT_RESET  = 8'h05;
  localparam logic [7:0] CODE_CHANNEL     = 8'h06;
  localparam logic [7:0] CODE_DEST_NET    = 8'h07;
  localparam logic [7:0] CODE_SERIAL      = 8'h0B;
  localparam logic [7:0] CODE_VERSION     = 8'h0C;
  localparam logic [7:0] CODE_RX_LEVEL    = 8'h0D;
  localparam logic [7:0] CODE_ERROR_WORD  = 8'h0E;
  localparam logic [7:0] CODE_TX_POWER    = 8'h11;

  localparam logic [7:0] LEN_NONE         = 8'h00;
  localparam logic [7:0] LEN_ONE          = 8'h01;
  localparam logic [7:0] LEN_ERROR_WORD   = 8'h02;
  localparam logic [7:0] LEN_VERSION      = 8'h03;
  localparam logic [7:0] LEN_SERIAL       = 8'h04;
  localparam logic [7:0] STATUS_OK        = 8'h00;

  localparam logic [7:0] MODE_TRANSPARENT = 8'h00;
  localparam logic [7:0] MODE_COMMAND     = 8'h10;

  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_SETTINGS     = 8'h04;
  localparam logic [7:0] REG_STATUS       = 8'h08;
  localparam int         CTRL_ENABLE_BIT  = 0;
  localparam logic       CTRL_ENABLE_RST  = 1'b1;
  localparam int         STAT_MODE_BIT    = 16;
  localparam int         STAT_BUSY_BIT    = 17;

  localparam int         TX_IDX_W         = 3;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  len;
    logic [31:0] payload;
  } tx_req_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_CMD  = 3'b001,
    P_LEN  = 3'b010,
    P_PAY  = 3'b011,
    P_SUM  = 3'b100,
    P_BUSY = 3'b101
  } parse_state_t;

endpackage : cmd_interp_pkg

/* rtl/reply_framer.sv */
module reply_framer
  import cmd_interp_pkg::*;
(
  input  wire logic    i_clock,
  input  wire logic    i_reset,
  input  wire logic    i_start,
  input  wire tx_req_t i_req,
  input  wire logic    i_tx_ready,
  output logic [7:0]   o_tx_byte,
  output logic         o_tx_valid,
  output logic         o_busy,
  output logic         o_done
);

  typedef struct packed {
    tx_req_t               req;
    logic [TX_IDX_W-1:0]   idx;
    logic [7:0]            csum;
    logic [7:0]            data;
    logic                  valid;
    logic                  busy;
    logic                  done;
  } framer_state_t;

  framer_state_t s_reg;
  framer_state_t s_next;
  logic [TX_IDX_W-1:0] last_idx;
  logic [TX_IDX_W-1:0] nidx;
  logic [7:0]          ncsum;

  // Payload is sent from the top byte down, so multi-byte fields go MSB first.
  function automatic logic [7:0] pick(input tx_req_t r,
                                      input logic [TX_IDX_W-1:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      3'd1: b = r.code;
      3'd2: b = r.len;
      3'd3: b = r.payload[31:24];
      3'd4: b = r.payload[23:16];
      3'd5: b = r.payload[15:8];
      3'd6: b = r.payload[7:0];
      default: b = FRAME_START;
    endcase
    return b;
  endfunction : pick

  always_comb begin
    s_next   = s_reg;
    s_next.done = 1'b0;
    last_idx = s_reg.req.len[TX_IDX_W-1:0] + 3'd3;
    nidx     = s_reg.idx + 3'd1;
    ncsum    = s_reg.csum ^ s_reg.data;
    if (!s_reg.busy && i_start) begin
      s_next.req   = i_req;
      s_next.idx   = '0;
      s_next.csum  = 8'h00;
      s_next.data  = FRAME_START;
      s_next.valid = 1'b1;
      s_next.busy  = 1'b1;
    end else if (s_reg.valid && i_tx_ready) begin
      if (s_reg.idx == last_idx) begin
        s_next.valid = 1'b0;
        s_next.busy  = 1'b0;
        s_next.done  = 1'b1;
      end else begin
        s_next.idx  = nidx;
        s_next.csum = ncsum;
        s_next.data = (nidx == last_idx) ? ncsum : pick(s_reg.req, nidx);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_tx_byte  = s_reg.data;
  assign o_tx_valid = s_reg.valid;
  assign o_busy     = s_reg.busy;
  assign o_done     = s_reg.done;

endmodule : reply_framer

/* rtl/host_command_interpreter.sv */
// Overview of operation
// - Version query answers major, minor, revision.
// - Serial query answers four bytes, MSB first.
// - Reset confirmed first, reset after last byte.
// - Level query answers last receive level byte.
// - Error query answers two-byte error word.
// - Error word zero when clean, cleared once the query is accepted.
// - Mode change adopted and echoed back.
// - Transparent mode 0x00, command mode 0x10.
// - Frames executed only in command mode.
// - Mode kept in volatile settings only.
// - Any reset restores runtime settings to start.
// - Power byte stored and echoed back.
// - Channel byte stored and echoed back.
// - Network id stored, confirmed with zero status.
//
// Chosen here: the strobed register port and the address map.
module host_command_interpreter
  import cmd_interp_pkg::*;
#(
  parameter logic [7:0]  VER_MAJOR      = 8'h01,
  parameter logic [7:0]  VER_MINOR      = 8'h00,
  parameter logic [7:0]  VER_REVISION   = 8'h00,
  // Arbitrary value; the product id sits in the top byte.
  parameter logic [31:0] SERIAL_NUMBER  = 32'h1000_0001,
  parameter logic [7:0]  START_MODE     = MODE_COMMAND,
  parameter logic [7:0]  START_POWER    = 8'h00,
  parameter logic [7:0]  START_CHANNEL  = 8'h00,
  parameter logic [7:0]  START_DEST_NET = 8'h00
)
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_valid,
  output logic             o_rx_ready,
  output logic [7:0]       o_tx_byte,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  input  wire logic [7:0]  i_rx_level,
  input  wire logic [15:0] i_error_set,
  output logic             o_soft_reset,
  output logic [7:0]       o_mode,
  output logic [7:0]       o_tx_power,
  output logic [7:0]       o_channel,
  output logic [7:0]       o_dest_network,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  output logic [31:0]      o_reg_rdata
);

  typedef struct packed {
    parse_state_t st;
    logic [7:0]   code;
    logic [7:0]   len;
    logic [7:0]   cnt;
    logic [7:0]   arg;
    logic [7:0]   csum;
    logic         rst_pend;
    logic [7:0]   mode;
    logic [7:0]   power;
    logic [7:0]   channel;
    logic [7:0]   dest_net;
    logic [15:0]  err;
    logic         enable;
    logic [31:0]  rdata;
    logic         start;
    tx_req_t      req;
    logic         soft_rst;
    logic         rx_ready;
  } interp_state_t;

  interp_state_t s_reg;
  interp_state_t s_next;
  interp_state_t s_reset;

  logic        tx_busy;
  logic        tx_done;
  logic        take;
  logic        accept;
  logic        err_clear;
  logic        len_ok;
  logic        rst_pend_next;
  logic [7:0]  reply_code;
  logic [7:0]  mode_next;
  logic [7:0]  power_next;
  logic [7:0]  channel_next;
  logic [7:0]  dest_net_next;
  logic [15:0] err_next;
  logic [31:0] rdata_next;
  tx_req_t     reply;

  // The framer owns the reply link; the parser hands it one request.
  reply_framer u_framer (
    .i_clock    (i_clock),
    .i_reset    (i_reset),
    .i_start    (s_reg.start),
    .i_req      (s_reg.req),
    .i_tx_ready (i_tx_ready),
    .o_tx_byte  (o_tx_byte),
    .o_tx_valid (o_tx_valid),
    .o_busy     (tx_busy),
    .o_done     (tx_done)
  );

  // Start values shared by power-on and commanded reset.
  always_comb begin
    s_reset          = '0;
    s_reset.st       = P_IDLE;
    s_reset.mode     = START_MODE;
    s_reset.power    = START_POWER;
    s_reset.channel  = START_CHANNEL;
    s_reset.dest_net = START_DEST_NET;
    s_reset.enable   = CTRL_ENABLE_RST;
    s_reset.rx_ready = 1'b1;
  end

  // Expected payload length per request code; unknown codes never match.
  always_comb begin
    case (s_reg.code)
      CODE_VERSION,
      CODE_SERIAL,
      CODE_SOFT_RESET,
      CODE_RX_LEVEL,
      CODE_ERROR_WORD: len_ok = (s_reg.len == LEN_NONE);
      CODE_MODE_CHANGE,
      CODE_TX_POWER,
      CODE_CHANNEL,
      CODE_DEST_NET:   len_ok = (s_reg.len == LEN_ONE);
      default:         len_ok = 1'b0;
    endcase
  end

  // Reply contents; the payload is left-aligned so it leaves MSB first.
  always_comb begin
    reply_code    = s_reg.code | REPLY_BIT;
    reply         = '0;
    reply.code    = reply_code;
    reply.len     = LEN_ONE;
    case (s_reg.code)
      CODE_VERSION: begin
        reply.len     = LEN_VERSION;
        reply.payload = {VER_MAJOR, VER_MINOR, VER_REVISION, 8'h00};
      end
      CODE_SERIAL: begin
        reply.len     = LEN_SERIAL;
        reply.payload = SERIAL_NUMBER;
      end
      CODE_SOFT_RESET: begin
        reply.payload = {STATUS_OK, 24'h000000};
      end
      CODE_RX_LEVEL: begin
        reply.payload = {i_rx_level, 24'h000000};
      end
      CODE_ERROR_WORD: begin
        reply.len     = LEN_ERROR_WORD;
        reply.payload = {s_reg.err, 16'h0000};
      end
      CODE_MODE_CHANGE,
      CODE_TX_POWER,
      CODE_CHANNEL: begin
        reply.payload = {s_reg.arg, 24'h000000};
      end
      CODE_DEST_NET: begin
        reply.payload = {STATUS_OK, 24'h000000};
      end
      default: begin
        reply.payload = '0;
      end
    endcase
  end

  // Acceptance decode stands apart so the per-bit error logic below can
  // see the clear without feeding back through the parser process.
  always_comb begin
    take      = i_rx_valid && s_reg.rx_ready;
    accept    = (s_reg.st == P_SUM) && take &&
                (i_rx_byte == s_reg.csum) && len_ok;
    err_clear = accept && (s_reg.code == CODE_ERROR_WORD);
  end

  // Each error bit is sticky; a set in the reporting cycle beats the clear.
  for (genvar g = 0; g < $bits(err_next); g++) begin : g_err_bit
    assign err_next[g] = i_error_set[g] |
                         (s_reg.err[g] & ~err_clear);
  end

  // Volatile settings change only on an accepted frame or on a reset.
  always_comb begin
    mode_next     = s_reg.mode;
    power_next    = s_reg.power;
    channel_next  = s_reg.channel;
    dest_net_next = s_reg.dest_net;
    rst_pend_next = s_reg.rst_pend;
    if (accept) begin
      case (s_reg.code)
        CODE_MODE_CHANGE: mode_next     = s_reg.arg;
        CODE_TX_POWER:    power_next    = s_reg.arg;
        CODE_CHANNEL:     channel_next  = s_reg.arg;
        CODE_DEST_NET:    dest_net_next = s_reg.arg;
        CODE_SOFT_RESET:  rst_pend_next = 1'b1;
        default:          rst_pend_next = s_reg.rst_pend;
      endcase
    end
  end

  // Register read answer; unmapped addresses and idle cycles read as zero.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_reg_read) begin
      case (i_reg_addr)
        REG_CTRL: begin
          rdata_next[CTRL_ENABLE_BIT] = s_reg.enable;
        end
        REG_SETTINGS: begin
          rdata_next = {s_reg.mode, s_reg.power, s_reg.channel,
                        s_reg.dest_net};
        end
        REG_STATUS: begin
          rdata_next[15:0]          = s_reg.err;
          rdata_next[STAT_MODE_BIT] = (s_reg.mode == MODE_COMMAND);
          rdata_next[STAT_BUSY_BIT] = (s_reg.st == P_BUSY) || tx_busy;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Parser and handshake state; settings and answers come from above.
  always_comb begin
    s_next          = s_reg;
    s_next.start    = 1'b0;
    s_next.soft_rst = 1'b0;
    s_next.rdata    = rdata_next;
    s_next.err      = err_next;
    s_next.mode     = mode_next;
    s_next.power    = power_next;
    s_next.channel  = channel_next;
    s_next.dest_net = dest_net_next;
    s_next.rst_pend = rst_pend_next;

    case (s_reg.st)
      P_IDLE: begin
        // Frames are only parsed while in command mode and enabled.
        if (take && i_rx_byte == FRAME_START && s_reg.enable &&
            s_reg.mode == MODE_COMMAND) begin
          s_next.csum = i_rx_byte;
          s_next.st   = P_CMD;
        end
      end
      P_CMD: begin
        if (take) begin
          // Any code is taken here; unknown ones fail the length check.
          s_next.code = i_rx_byte;
          s_next.csum = s_reg.csum ^ i_rx_byte;
          s_next.st   = P_LEN;
        end
      end
      P_LEN: begin
        if (take) begin
          s_next.len  = i_rx_byte;
          s_next.cnt  = 8'h00;
          s_next.csum = s_reg.csum ^ i_rx_byte;
          // A zero length skips straight to the checksum byte.
          s_next.st   = (i_rx_byte == LEN_NONE) ? P_SUM : P_PAY;
        end
      end
      P_PAY: begin
        if (take) begin
          // Only the first payload byte is kept; the rest feed the checksum.
          if (s_reg.cnt == 8'h00) begin
            s_next.arg = i_rx_byte;
          end
          s_next.cnt  = s_reg.cnt + 8'h01;
          s_next.csum = s_reg.csum ^ i_rx_byte;
          if (s_reg.cnt == s_reg.len - 8'h01) begin
            s_next.st = P_SUM;
          end
        end
      end
      P_SUM: begin
        if (take) begin
          // A bad checksum or an unknown request drops the frame silently.
          if (accept) begin
            s_next.start    = 1'b1;
            s_next.req      = reply;
            s_next.rx_ready = 1'b0;
            s_next.st       = P_BUSY;
          end else begin
            s_next.st = P_IDLE;
          end
        end
      end
      P_BUSY: begin
        // Request bytes are refused until the reply has left.
        if (tx_done) begin
          s_next.rx_ready = 1'b1;
          s_next.st       = P_IDLE;
        end
      end
      default: begin
        s_next.st = P_IDLE;
      end
    endcase

    // The commanded reset fires only once the confirmation is fully out.
    // A read answer due in the same cycle still comes out.
    if (s_reg.st == P_BUSY && tx_done && s_reg.rst_pend) begin
      s_next          = s_reset;
      s_next.enable   = s_reg.enable;
      s_next.rdata    = rdata_next;
      s_next.soft_rst = 1'b1;
    end

    // A write after the reset above keeps software's enable in force.
    if (i_reg_write && i_reg_addr == REG_CTRL) begin
      s_next.enable = i_reg_wdata[CTRL_ENABLE_BIT];
    end
  end

  // Power-on reset loads the start values; the commanded reset loads them too but keeps enable and the read answer.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_reg <= s_reset;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rx_ready     = s_reg.rx_ready;
  assign o_soft_reset   = s_reg.soft_rst;
  assign o_mode         = s_reg.mode;
  assign o_tx_power     = s_reg.power;
  assign o_channel      = s_reg.channel;
  assign o_dest_network = s_reg.dest_net;
  assign o_reg_rdata    = s_reg.rdata;

endmodule : host_command_interpreter

/* verif/host_command_interpreter_props.sv */
module host_command_interpreter_props
  import cmd_interp_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_read,
  input wire logic        i_tx_ready,
  input wire logic        o_rx_ready,
  input wire logic [7:0]  o_tx_byte,
  input wire logic        o_tx_valid,
  input wire logic        o_soft_reset,
  input wire logic [7:0]  o_mode,
  input wire logic [7:0]  o_tx_power,
  input wire logic [7:0]  o_channel,
  input wire logic [7:0]  o_dest_network,
  input wire logic [31:0] o_reg_rdata
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  reply_start_a: assert property ($fell(o_rx_ready) |=> o_tx_valid)
    else $error("reply did not start");
  start_byte_a: assert property ($rose(o_tx_valid) |-> o_tx_byte == 8'h02)
    else $error("reply start byte wrong");
  code_bit_a: assert property ($rose(o_tx_valid) && i_tx_ready |=>
    o_tx_valid && o_tx_byte[6])
    else $error("reply code bit clear");
  byte_hold_a: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_byte))
    else $error("reply byte moved");
  one_frame_a: assert property (o_tx_valid |-> !o_rx_ready)
    else $error("request taken during reply");
  ready_back_a: assert property ($fell(o_tx_valid) |=> o_rx_ready)
    else $error("ready not back");
  reset_late_a: assert property (o_soft_reset |->
    !o_tx_valid && !$past(o_tx_valid))
    else $error("soft reset before reply end");
  reset_restore_a: assert property (o_soft_reset |-> o_mode == 8'h10 &&
    {o_tx_power, o_channel, o_dest_network} == 24'h0)
    else $error("settings not restored");
  mode_gate_a: assert property (o_mode != 8'h10 && o_rx_ready |->
    ##2 !o_tx_valid)
    else $error("reply outside command mode");
  settings_read_a: assert property ($past(i_reg_read) &&
    $past(i_reg_addr) == REG_SETTINGS |-> o_reg_rdata ==
    $past({o_mode, o_tx_power, o_channel, o_dest_network}))
    else $error("settings word wrong");

  reply_c: cover property ($rose(o_tx_valid));
  stall_c: cover property (o_tx_valid && !i_tx_ready);
  reset_c: cover property (o_soft_reset);
  quiet_c: cover property (o_mode == 8'h00);
endmodule : host_command_interpreter_props

bind host_command_interpreter host_command_interpreter_props props (
  .i_clock, .i_reset, .i_reg_addr, .i_reg_read, .i_tx_ready, .o_rx_ready,
  .o_tx_byte, .o_tx_valid, .o_soft_reset, .o_mode, .o_tx_power, .o_channel,
  .o_dest_network, .o_reg_rdata
);

/* verif/host_model.sv */
module host_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_valid,
  input  wire logic       i_slow,
  output logic            o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic       tick = 1'b0;
  // A slow host takes a byte only every other cycle, to stretch replies.
  always @(posedge i_clock) begin
    tick <= ~tick;
    if (i_valid && o_ready) got.push_back(i_byte);
  end
  assign o_ready = ~i_slow | tick;
endmodule : host_model

/* verif/host_command_interpreter_tb.sv */
module host_command_interpreter_tb
  import cmd_interp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, rxv = 1'b0, slow = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, rxr, txv, txr, srst;
  logic [7:0]  rxb = 8'h00, lvl = 8'h00, ra = 8'h00, txb;
  logic [7:0]  mode, pwr, chan, net;
  logic [15:0] eset = 16'h0000;
  logic [31:0] wd = 32'h0, rdat;
  int          num_errors = 0, num_checks = 0;
  int          srst_seen = 0;

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (srst === 1'b1) srst_seen++;
  end

  host_command_interpreter dut (
    .i_clock(clk), .i_reset(rst), .i_rx_byte(rxb), .i_rx_valid(rxv),
    .o_rx_ready(rxr), .o_tx_byte(txb), .o_tx_valid(txv), .i_tx_ready(txr),
    .i_rx_level(lvl), .i_error_set(eset), .o_soft_reset(srst),
    .o_mode(mode), .o_tx_power(pwr), .o_channel(chan),
    .o_dest_network(net), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdat));
  host_model host (
    .i_clock(clk), .i_byte(txb), .i_valid(txv), .i_slow(slow),
    .o_ready(txr));

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic void seal(ref logic [7:0] q[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[k]) s ^= q[k];
    q.push_back(s);
  endfunction : seal

  task automatic reg_io(input logic w, input logic [7:0] a,
                        input logic [31:0] x);
    @(posedge clk);
    ra <= a;
    wd <= x;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 if (!w) chk(rdat, x);
  endtask : reg_io

  task automatic pulse_err(input logic [15:0] v);
    @(posedge clk);
    eset <= v;
    @(posedge clk);
    eset <= 16'h0000;
  endtask : pulse_err

  // A reply code of zero means the frame must be dropped silently.
  task automatic run(input logic [7:0] c, l, input logic [31:0] p,
                     input logic [7:0] bad, rc, rl, input logic [31:0] rp);
    logic [7:0] b[$];
    logic [7:0] e[$];
    int         n;
    b = {FRAME_START, c, l};
    for (n = int'(l) - 1; n >= 0; n--) b.push_back(p[8*n +: 8]);
    seal(b);
    b[b.size()-1] ^= bad;
    for (n = 0; n < 50 && rxr !== 1'b1; n++) @(posedge clk);
    if (rxr !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t request link stuck", $time);
      wrap_up();
    end
    foreach (b[k]) begin
      @(posedge clk);
      rxb <= b[k];
      rxv <= 1'b1;
    end
    @(posedge clk);
    rxv <= 1'b0;
    if (rc != 8'h00) begin
      e = {FRAME_START, rc, rl};
      for (n = int'(rl) - 1; n >= 0; n--) e.push_back(rp[8*n +: 8]);
      seal(e);
    end
    for (n = 0; n < 80 && host.got.size() < e.size(); n++) @(posedge clk);
    if (host.got.size() < e.size()) begin
      num_errors++;
      $display("[ERR] %0t reply timeout", $time);
      wrap_up();
    end
    repeat (20) @(posedge clk);
    chk(host.got.size(), e.size());
    foreach (e[k]) chk(host.got[k], e[k]);
    host.got.delete();
    $display("frame %h done", c);
  endtask : run

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Version and serial expectations are the design's default values.
    run(CODE_VERSION, 8'h00, 0, 0, 8'h4C, 8'h03, 32'h0001_0000);
    slow <= 1'b1;
    run(CODE_SERIAL, 8'h00, 0, 0, 8'h4B, 8'h04, 32'h1000_0001);
    slow <= 1'b0;
    lvl <= 8'hBD;
    run(CODE_RX_LEVEL, 8'h00, 0, 0, 8'h4D, 8'h01, 32'hBD);
    run(CODE_ERROR_WORD, 8'h00, 0, 0, 8'h4E, 8'h02, 32'h0);
    pulse_err(16'h0102);
    reg_io(1'b0, REG_STATUS, 32'h0001_0102);
    run(CODE_ERROR_WORD, 8'h00, 0, 0, 8'h4E, 8'h02, 32'h0102);
    run(CODE_ERROR_WORD, 8'h00, 0, 0, 8'h4E, 8'h02, 32'h0);
    run(CODE_TX_POWER, 8'h01, 32'h0E, 0, 8'h51, 8'h01, 32'h0E);
    run(CODE_CHANNEL, 8'h01, 32'h6C, 0, 8'h46, 8'h01, 32'h6C);
    run(CODE_DEST_NET, 8'h01, 32'h55, 0, 8'h47, 8'h01, 32'h00);
    reg_io(1'b0, REG_SETTINGS, 32'h100E_6C55);
    run(CODE_CHANNEL, 8'h01, 32'h22, 8'h01, 0, 0, 0);
    run(CODE_CHANNEL, 8'h02, 32'h2233, 0, 0, 0, 0);
    chk(chan, 8'h6C);
    reg_io(1'b1, REG_CTRL, 32'h0);
    run(CODE_VERSION, 8'h00, 0, 0, 0, 0, 0);
    reg_io(1'b1, REG_CTRL, 32'h1);
    reg_io(1'b0, REG_CTRL, 32'h1);
    reg_io(1'b0, 8'h0C, 32'h0);
    pulse_err(16'h0004);
    run(CODE_SOFT_RESET, 8'h00, 0, 0, 8'h45, 8'h01, 32'h00);
    chk({pwr, chan, net}, 32'h0);
    chk(srst_seen, 1);
    run(CODE_ERROR_WORD, 8'h00, 0, 0, 8'h4E, 8'h02, 32'h0);
    run(CODE_MODE_CHANGE, 8'h01, 0, 0, 8'h44, 8'h01, 32'h00);
    chk(mode, 8'h00);
    run(CODE_VERSION, 8'h00, 0, 0, 0, 0, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(mode, 8'h10);
    run(CODE_VERSION, 8'h00, 0, 0, 8'h4C, 8'h03, 32'h0001_0000);
    wrap_up();
  end
endmodule : host_command_interpreter_tb
